// file: verilog/thsp_pkg.sv
// Behaviour
// - config seven bit 0 selects pin function
// - select clear: activity indicator on pin
// - bc/rt/selective monitor: low during message
// - word monitor: low while monitor online
// - rt, select set: reset low two clocks
// - bc/monitor, select set: pin stays high
// - pulse mode: one low pulse about 500 ns
// - level mode: low until cleared
// - interrupt-reset write releases level interrupt
// - auto-clear: status read releases level interrupt
// - both status pending: both reads needed
// - clock of 20, 16, 12 or 10 MHz; the package timing assumes 25 MHz
// - inhibit input high shuts that transmitter
// - master clear is active low reset
// - tag clock counts only with bits 7-9 set
package thsp_pkg;
  // ****************************************
  // configuration fields
  // ****************************************
  localparam int unsigned THSP_CFG7_SEL_BIT = 0;
  localparam int unsigned THSP_CFG2_LEVEL_BIT = 3;
  localparam int unsigned THSP_CFG2_AUTOCLR_BIT = 4;
  localparam int unsigned THSP_CFG2_TAG_LO_BIT = 7;
  localparam int unsigned THSP_CFG2_TAG_HI_BIT = 9;
  localparam int unsigned THSP_SR_INTRST_BIT = 2;
  localparam logic [15:0] THSP_CFG2_RESET = 16'h0000;
  localparam logic [15:0] THSP_CFG7_RESET = 16'h0000;

  // ****************************************
  // host wishbone registers (byte addresses)
  // ****************************************
  localparam logic [3:0] THSP_ADR_CTRL = 4'h0;
  localparam logic [3:0] THSP_ADR_STAT = 4'h4;
  localparam logic [3:0] THSP_ADR_MASK = 4'h8;
  localparam logic [3:0] THSP_ADR_TAG = 4'hc;
  localparam int unsigned THSP_CTRL_INH_A_BIT = 0;
  localparam int unsigned THSP_CTRL_INH_B_BIT = 1;
  localparam int unsigned THSP_CTRL_CLEAR_BIT = 2;
  localparam int unsigned THSP_CTRL_TAGCLK_BIT = 3;
  localparam int unsigned THSP_EV_INT_BIT = 0;
  localparam int unsigned THSP_EV_MODE_CMD_RESET_N_BIT = 1;
  localparam logic [1:0] THSP_MASK_RESET = 2'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned THSP_CLK_HZ = 25000000;
  localparam int unsigned THSP_PULSE_NS = 500;
  localparam int unsigned THSP_PULSE_CYC =
    (THSP_PULSE_NS * (THSP_CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned THSP_MODE_CMD_RESET_N_CYC = 2;

  typedef enum logic [1:0] {THSP_MODE_BC, THSP_MODE_RT, THSP_MODE_SMON, THSP_MODE_WMON} thsp_mode_t;
endpackage

// file: verilog/thsp_if.sv
`timescale 1ns/10ps
interface thsp_if;
  logic activity_pin_n;
  logic int_n;
  logic xmit_inhibit_a;
  logic xmit_inhibit_b;
  logic master_clear_n;
  logic tag_clk;
  modport dev (output activity_pin_n, output int_n, input xmit_inhibit_a, input xmit_inhibit_b,
               input master_clear_n, input tag_clk);
  modport host (input activity_pin_n, input int_n, output xmit_inhibit_a, output xmit_inhibit_b,
                output master_clear_n, output tag_clk);
endinterface

// file: verilog/thsp_dev.sv
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/10ps
module thsp_dev
  import thsp_pkg::*;
(
  input wire logic clk_i,
  thsp_if.dev pins,
  input wire logic [15:0] cfg2_i,
  input wire logic [15:0] cfg7_i,
  input wire thsp_mode_t mode_i,
  input wire logic msg_busy_i,
  input wire logic mon_online_i,
  input wire logic rt_reset_cmd_i,
  input wire logic int_event_i,
  input wire logic [1:0] int_pending_i,
  input wire logic [1:0] stat_read_i,
  input wire logic start_reset_wr_i,
  input wire logic [15:0] start_reset_data_i,
  output logic tx_enable_a_o,
  output logic tx_enable_b_o,
  output logic [15:0] time_tag_o
);
  logic rst;
  logic [1:0] clr_sync_q;
  logic [1:0] inh_a_q;
  logic [1:0] inh_b_q;
  logic [2:0] tag_q;
  logic [3:0] pulse_cnt_q;
  logic level_q;
  logic [1:0] need_q;
  logic [1:0] mode_cmd_reset_n_cnt_q;
  logic act_q;
  logic int_n_q;

  // ****************************************
  // master clear and pin synchronisers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    clr_sync_q <= {clr_sync_q[0], pins.master_clear_n};
    inh_a_q <= {inh_a_q[0], pins.xmit_inhibit_a};
    inh_b_q <= {inh_b_q[0], pins.xmit_inhibit_b};
    tag_q <= {tag_q[1:0], pins.tag_clk};
  end
  assign rst = ~clr_sync_q[1];
  assign tx_enable_a_o = ~inh_a_q[1];
  assign tx_enable_b_o = ~inh_b_q[1];

  // ****************************************
  // time tag
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst)
      time_tag_o <= 16'h0000;
    else if (&cfg2_i[THSP_CFG2_TAG_HI_BIT:THSP_CFG2_TAG_LO_BIT] && tag_q[1] && !tag_q[2])
      time_tag_o <= time_tag_o + 16'h0001;
  end

  // ****************************************
  // interrupt
  // ****************************************
  // pulse width is a cycle count reckoned from the package clock rate; retune it for another clock
  always_ff @(posedge clk_i)
  begin
    if (rst)
    begin
      pulse_cnt_q <= 4'h0;
      level_q <= 1'b0;
      need_q <= 2'h0;
    end
    else
    begin
      if (int_event_i && !cfg2_i[THSP_CFG2_LEVEL_BIT])
        pulse_cnt_q <= 4'(THSP_PULSE_CYC);
      else if (pulse_cnt_q != 4'h0)
        pulse_cnt_q <= pulse_cnt_q - 4'h1;
      // a new event wins over a clear in the same cycle
      if (int_event_i && cfg2_i[THSP_CFG2_LEVEL_BIT])
      begin
        level_q <= 1'b1;
        need_q <= int_pending_i;
      end
      else if (start_reset_wr_i && start_reset_data_i[THSP_SR_INTRST_BIT])
        level_q <= 1'b0;
      else if (cfg2_i[THSP_CFG2_AUTOCLR_BIT] && level_q)
      begin
        need_q <= need_q & ~stat_read_i;
        if ((need_q & ~stat_read_i) == 2'h0)
          level_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // shared activity / reset pin
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst)
      mode_cmd_reset_n_cnt_q <= 2'h0;
    else if (rt_reset_cmd_i && mode_i == THSP_MODE_RT)
      mode_cmd_reset_n_cnt_q <= 2'(THSP_MODE_CMD_RESET_N_CYC);
    else if (mode_cmd_reset_n_cnt_q != 2'h0)
      mode_cmd_reset_n_cnt_q <= mode_cmd_reset_n_cnt_q - 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst)
    begin
      act_q <= 1'b1;
      int_n_q <= 1'b1;
    end
    else
    begin
      int_n_q <= ~(level_q || pulse_cnt_q != 4'h0);
      if (!cfg7_i[THSP_CFG7_SEL_BIT])
      begin
        case (mode_i)
          THSP_MODE_WMON: act_q <= ~mon_online_i;
          default: act_q <= ~msg_busy_i;
        endcase
      end
      else if (mode_i == THSP_MODE_RT)
        act_q <= ~((rt_reset_cmd_i) || mode_cmd_reset_n_cnt_q > 2'h1);
      else
        act_q <= 1'b1;
    end
  end
  assign pins.activity_pin_n = act_q;
  assign pins.int_n = int_n_q;
endmodule

// file: verilog/thsp_host.sv
`timescale 1ns/10ps
module thsp_host
  import thsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  thsp_if.host pins,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  output logic irq_o
);
  logic [1:0] int_s_q;
  logic [1:0] act_s_q;
  logic [3:0] ctrl_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [15:0] tag_cnt_q;
  logic int_d1_q;
  logic act_d1_q;
  logic req;
  logic wr;

  // ****************************************
  // pin synchronisers and edge detect
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    int_s_q <= {int_s_q[0], pins.int_n};
    act_s_q <= {act_s_q[0], pins.activity_pin_n};
    int_d1_q <= int_s_q[1];
    act_d1_q <= act_s_q[1];
  end

  assign req = cyc_i && stb_i && !ack_o;
  // writes land on the edge where the master sees ack, so a held request is applied once
  assign wr = cyc_i && stb_i && we_i && sel_i[0] && ack_o;

  // ****************************************
  // wishbone slave
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= req;
      dat_o <= 32'h00000000;
      if (req && !we_i)
        case (adr_i)
          THSP_ADR_CTRL: dat_o <= {28'h0000000, ctrl_q};
          THSP_ADR_STAT: dat_o <= {30'h0, stat_q};
          THSP_ADR_MASK: dat_o <= {30'h0, mask_q};
          THSP_ADR_TAG: dat_o <= {16'h0000, tag_cnt_q};
          default: dat_o <= 32'h00000000;
        endcase
    end
  end

  // ****************************************
  // control and status
  // ****************************************
  // master clear held low by reset, so the device restarts with us
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= 4'h0;
      mask_q <= THSP_MASK_RESET;
      stat_q <= 2'h0;
      tag_cnt_q <= 16'h0000;
    end
    else
    begin
      if (wr && adr_i == THSP_ADR_CTRL)
        ctrl_q <= dat_i[3:0];
      if (wr && adr_i == THSP_ADR_MASK)
        mask_q <= dat_i[1:0];
      // only rising tag clock writes are counted
      if (wr && adr_i == THSP_ADR_CTRL && dat_i[THSP_CTRL_TAGCLK_BIT] && !ctrl_q[THSP_CTRL_TAGCLK_BIT])
        tag_cnt_q <= tag_cnt_q + 16'h0001;
      // set wins over the read clear
      stat_q <= ((req && !we_i && adr_i == THSP_ADR_STAT) ? 2'h0 : stat_q)
                | {act_d1_q && !act_s_q[1], int_d1_q && !int_s_q[1]};
    end
  end

  assign irq_o = |(stat_q & mask_q);
  assign pins.xmit_inhibit_a = ctrl_q[THSP_CTRL_INH_A_BIT];
  assign pins.xmit_inhibit_b = ctrl_q[THSP_CTRL_INH_B_BIT];
  assign pins.master_clear_n = ~(rst_i | ctrl_q[THSP_CTRL_CLEAR_BIT]);
  assign pins.tag_clk = ctrl_q[THSP_CTRL_TAGCLK_BIT];
endmodule

// file: tb/thsp_asserts.sv
`timescale 1ns/10ps
module thsp_asserts
  import thsp_pkg::*;
(
  input wire logic clk_i,
  input wire logic master_clear_n,
  input wire logic activity_pin_n,
  input wire logic int_n,
  input wire logic xmit_inhibit_a,
  input wire logic tx_enable_a_o,
  input wire logic [15:0] cfg2_i,
  input wire logic [15:0] cfg7_i,
  input wire thsp_mode_t mode_i,
  input wire logic msg_busy_i,
  input wire logic mon_online_i,
  input wire logic rt_reset_cmd_i,
  input wire logic int_event_i,
  input wire logic start_reset_wr_i,
  input wire logic [15:0] start_reset_data_i
);
  // ********
  // pin checks, idle while master clear is low
  // ********
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!master_clear_n);
  AST_ACT: assert property
    ((!cfg7_i[0] && mode_i != THSP_MODE_WMON) [*2] |-> activity_pin_n == !$past(msg_busy_i))
    else $error("activity pin not following busy");
  AST_WMON: assert property
    ((!cfg7_i[0] && mode_i == THSP_MODE_WMON) [*2] |-> activity_pin_n == !$past(mon_online_i))
    else $error("activity pin not following monitor");
  AST_MODE_CMD_RESET_N: assert property
    (cfg7_i[0] && mode_i == THSP_MODE_RT && rt_reset_cmd_i |=> !activity_pin_n [*2] ##1 activity_pin_n)
    else $error("reset pulse not two cycles");
  AST_HIGH: assert property
    ((cfg7_i[0] && !rt_reset_cmd_i) [*3] |-> activity_pin_n)
    else $error("select set but pin low");
  // the pin is registered behind the counter, so the low span starts two edges after the event
  AST_PULSE: assert property
    (!cfg2_i[3] && int_event_i |=> ##1 !int_n [*8] ##1 !int_n [*5] ##1 int_n)
    else $error("interrupt pulse width wrong");
  AST_LEVEL: assert property
    (cfg2_i[3] && int_event_i |=> ##1 !int_n [*8])
    else $error("level interrupt not held");
  AST_CLR: assert property
    (cfg2_i[3] && start_reset_wr_i && start_reset_data_i[2] && !int_event_i |-> ##[1:2] int_n)
    else $error("interrupt reset ignored");
  AST_INH: assert property
    ($stable(xmit_inhibit_a) [*3] |-> tx_enable_a_o == !xmit_inhibit_a)
    else $error("inhibit a not obeyed");
endmodule

// file: tb/tb_terminal_host_signal_pins.sv
`timescale 1ns/10ps
module tb_terminal_host_signal_pins import thsp_pkg::*;;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq, busy = 0, onl = 0, rtc = 0, iev = 0, srw = 0, txa, txb;
  logic [3:0] adr = 4'h0;
  logic [31:0] dw = 32'h0, dr, q;
  logic [15:0] cfg2 = 16'h0, cfg7 = 16'h0, srd = 16'h0, tag, t0;
  logic [1:0] pend = 2'h0, rd = 2'h0;
  thsp_mode_t mode = THSP_MODE_BC;
  int n_errors = 0, n_checks = 0, n;
  thsp_if thsp_if_i();
  wire act_n = thsp_if_i.activity_pin_n;
  wire int_n = thsp_if_i.int_n;
  thsp_dev thsp_dev_i(.clk_i(clk_i), .pins(thsp_if_i.dev), .cfg2_i(cfg2), .cfg7_i(cfg7), .mode_i(mode),
    .msg_busy_i(busy), .mon_online_i(onl), .rt_reset_cmd_i(rtc), .int_event_i(iev), .int_pending_i(pend),
    .stat_read_i(rd), .start_reset_wr_i(srw), .start_reset_data_i(srd), .tx_enable_a_o(txa),
    .tx_enable_b_o(txb), .time_tag_o(tag));
  thsp_host thsp_host_i(.clk_i(clk_i), .rst_i(rst_i), .pins(thsp_if_i.host), .adr_i(adr), .dat_i(dw),
    .dat_o(dr), .we_i(we), .sel_i(4'h1), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .irq_o(irq));
  thsp_asserts thsp_asserts_i(.clk_i(clk_i), .master_clear_n(thsp_if_i.master_clear_n),
    .activity_pin_n(act_n), .int_n(int_n), .xmit_inhibit_a(thsp_if_i.xmit_inhibit_a), .tx_enable_a_o(txa),
    .cfg2_i(cfg2), .cfg7_i(cfg7), .mode_i(mode), .msg_busy_i(busy), .mon_online_i(onl),
    .rt_reset_cmd_i(rtc), .int_event_i(iev), .start_reset_wr_i(srw), .start_reset_data_i(srd));
  // ********
  // shared tasks; values read right after an edge are the ones sampled there
  // ********
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = dr;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic cnt(input bit on_int, input string nm, input int e);
    n = 0;
    repeat (30)
    begin
      @(posedge clk_i);
      n += on_int ? (int_n === 1'b0) : (act_n === 1'b0);
    end
    chk(nm, e, n);
  endtask
  task automatic ev;
    @(posedge clk_i) iev <= 1;
    @(posedge clk_i) iev <= 0;
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_pin;
    @(posedge clk_i) busy <= 1;
    tick(3);
    chk("act_busy", 0, act_n);
    @(posedge clk_i) {busy, mode, onl} <= {1'b0, THSP_MODE_WMON, 1'b1};
    tick(3);
    chk("act_wmon", 0, act_n);
    @(posedge clk_i) {cfg7, mode} <= {16'h1, THSP_MODE_RT};
    tick(3);
    @(posedge clk_i) rtc <= 1;
    @(posedge clk_i) rtc <= 0;
    cnt(0, "mode_cmd_reset_n", THSP_MODE_CMD_RESET_N_CYC);
    @(posedge clk_i) {mode, busy} <= {THSP_MODE_BC, 1'b1};
    tick(3);
    chk("act_sel_bc", 1, act_n);
    @(posedge clk_i) {cfg7, busy, onl} <= 18'h0;
  endtask
  task automatic t_int;
    ev();
    cnt(1, "pulse", THSP_PULSE_CYC);
    chk("irq_masked", 0, irq);
    wb(1, THSP_ADR_MASK, 32'h1);
    tick(2);
    chk("irq_on", 1, irq);
    wb(0, THSP_ADR_STAT, 32'h0);
    chk("stat", 1, q[0]);
    tick(2);
    chk("irq_off", 0, irq);
    wb(0, 4'h2, 32'h0);
    chk("unmapped", 0, q);
    @(posedge clk_i) cfg2 <= 16'h0008;
    ev();
    tick(10);
    chk("level", 0, int_n);
    @(posedge clk_i) {srw, srd} <= {1'b1, 16'h0003};
    @(posedge clk_i) srd <= 16'h0004;
    @(posedge clk_i) srw <= 0;
    tick(3);
    chk("int_reset", 1, int_n);
    @(posedge clk_i) {cfg2, pend} <= {16'h0018, 2'h3};
    ev();
    tick(3);
    @(posedge clk_i) rd <= 2'h1;
    @(posedge clk_i) rd <= 2'h0;
    tick(3);
    chk("one_read", 0, int_n);
    @(posedge clk_i) rd <= 2'h2;
    @(posedge clk_i) rd <= 2'h0;
    tick(3);
    chk("auto_clr", 1, int_n);
  endtask
  task automatic t_inh_tag;
    wb(1, THSP_ADR_CTRL, 32'h1);
    tick(4);
    chk("txa_inh", 2'b01, {txa, txb});
    wb(1, THSP_ADR_CTRL, 32'h2);
    tick(4);
    chk("txb_inh", 2'b10, {txa, txb});
    t0 = tag;
    @(posedge clk_i) cfg2 <= 16'h0380;
    repeat (2)
    begin
      wb(1, THSP_ADR_CTRL, 32'h8);
      wb(1, THSP_ADR_CTRL, 32'h0);
    end
    tick(5);
    chk("tag_on", t0 + 16'h2, tag);
    @(posedge clk_i) cfg2 <= 16'h0180;
    wb(1, THSP_ADR_CTRL, 32'h8);
    wb(1, THSP_ADR_CTRL, 32'h0);
    tick(5);
    chk("tag_off", t0 + 16'h2, tag);
    wb(0, THSP_ADR_TAG, 32'h0);
    chk("host_tag", 32'h3, q);
    wb(1, THSP_ADR_CTRL, 32'h4);
    tick(4);
    chk("mclr_tag", 0, tag);
    wb(1, THSP_ADR_CTRL, 32'h0);
  endtask
  initial forever #20 clk_i = ~clk_i;
  initial
  begin
    tick(6);
    rst_i <= 0;
    tick(8);
    t_pin();
    t_int();
    t_inh_tag();
    wrap_up();
  end
  initial
  begin
    tick(5000);
    n_errors++;
    wrap_up();
  end
endmodule
